/* File: hw/ubr_pkg.sv */
package ubr_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned DIV_W    = 13;
  localparam int unsigned DIV_HI_W = 5;
  localparam int unsigned DIV_LO_W = 8;
  localparam int unsigned OVS_W    = 4;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  // Index is the printed offset, byte address is four times it
  localparam logic [ADDR_W-1:0] IDX_HIGH  = 12'h000;
  localparam logic [ADDR_W-1:0] IDX_LOW   = 12'h001;
  localparam logic [ADDR_W-1:0] IDX_STAT  = 12'h002;
  localparam logic [ADDR_W-1:0] ADDR_HIGH = {IDX_HIGH[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOW  = {IDX_LOW[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT[ADDR_W-3:0], 2'b00};

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned BRK_IE_BIT   = 7;
  localparam int unsigned EDGE_IE_BIT  = 6;
  localparam int unsigned STOP_SEL_BIT = 5;
  localparam int unsigned ST_ACTIVE    = 0;
  localparam int unsigned ST_ARMED     = 1;
  localparam int unsigned ST_BRK       = 2;
  localparam int unsigned ST_EDGE      = 3;
  localparam int unsigned ST_IRQ       = 4;
  localparam logic [REG_W-1:0]    HIGH_RST   = 8'h00;
  localparam logic [REG_W-1:0]    LOW_RST    = 8'h04;
  localparam logic [DIV_W-1:0]    DIV_ZERO   = 13'h0000;
  localparam logic [DIV_W-1:0]    CNT_START  = 13'h0001;
  localparam logic [OVS_W-1:0]    OVS_LAST   = 4'hf;
  localparam logic [DATA_W-1:0]   DATA_ZERO  = 32'h00000000;

  // ************************************************************
  // Types
  // ************************************************************
  // High register layout, bit 7 down to bit 0
  typedef struct packed {
    logic                brk_ie;
    logic                edge_ie;
    logic                stop_sel;
    logic [DIV_HI_W-1:0] div_hi;
  } ubr_high_t;

  // Settings handed to the rate generator
  typedef struct packed {
    logic             run;
    logic [DIV_W-1:0] divisor;
  } ubr_gen_cfg_t;

  // Tick pair out of the rate generator
  typedef struct packed {
    logic sample;
    logic bit_tick;
  } ubr_tick_t;

  typedef enum logic [1:0] {
    SEL_HIGH = 2'b00,
    SEL_LOW  = 2'b01,
    SEL_STAT = 2'b10,
    SEL_NONE = 2'b11
  } ubr_sel_t;

  typedef enum logic {
    APB_IDLE   = 1'b0,
    APB_ACCESS = 1'b1
  } ubr_apb_st_t;

endpackage : ubr_pkg

/* File: hw/ubr_baud_gen.sv */
`timescale 1ns/10ps
module ubr_baud_gen
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  // Settings
  input  wire ubr_pkg::ubr_gen_cfg_t i_cfg,
  // Ticks
  output ubr_pkg::ubr_tick_t         o_tick
);

  // ************************************************************
  // Modulo counter and oversample prescaler
  // ************************************************************
  logic [ubr_pkg::DIV_W-1:0] cnt;
  logic [ubr_pkg::DIV_W-1:0] next_cnt;
  logic [ubr_pkg::OVS_W-1:0] sub;
  logic [ubr_pkg::OVS_W-1:0] next_sub;
  ubr_pkg::ubr_tick_t        tick;
  ubr_pkg::ubr_tick_t        next_tick;

  // Sample tick every divisor cycles, bit tick every sixteen samples
  always_comb
  begin
    next_cnt  = cnt;
    next_sub  = sub;
    next_tick = '0;
    // stopped when off or zero
    // Run lags a zero divisor by a cycle, so the divisor is checked here too
    if (!i_cfg.run || (i_cfg.divisor == ubr_pkg::DIV_ZERO))
    begin
      // Held still, so no node toggles while off
      next_cnt = ubr_pkg::CNT_START;
      next_sub = '0;
    end
    // rate is clock over 16 times divisor
    else if (cnt >= i_cfg.divisor)
    begin
      // Compare, not equality: a smaller new divisor cannot strand the count
      next_cnt           = ubr_pkg::CNT_START;
      next_sub           = sub + 4'h1;
      next_tick.sample   = 1'b1;
      next_tick.bit_tick = (sub == ubr_pkg::OVS_LAST);
    end
    else
    begin
      next_cnt = cnt + 13'h0001;
    end
  end

  // Registers only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt  <= ubr_pkg::CNT_START;
      sub  <= '0;
      tick <= '0;
    end
    else
    begin
      cnt  <= next_cnt;
      sub  <= next_sub;
      tick <= next_tick;
    end
  end

  assign o_tick = tick;

endmodule : ubr_baud_gen

/* File: hw/ubr_regs.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module ubr_regs
#(
  // Cleared for the channel that lacks two stop bits
  parameter bit TWO_STOP_SUPPORT = 1'b1
)
(
  // Clock and reset
  input  wire logic                         I_CORE_CLK,
  input  wire logic                         I_RSTN,
  // APB slave
  input  wire logic [ubr_pkg::ADDR_W-1:0]   I_PADDR,
  input  wire logic                         I_PSEL,
  input  wire logic                         I_PENABLE,
  input  wire logic                         I_PWRITE,
  input  wire logic [ubr_pkg::DATA_W-1:0]   I_PWDATA,
  input  wire logic [3:0]                   I_PSTRB,
  output logic      [ubr_pkg::DATA_W-1:0]   O_PRDATA,
  output logic                              O_PREADY,
  output logic                              O_PSLVERR,
  // From control and status logic
  input  wire logic                         I_RX_ENABLE,
  input  wire logic                         I_TX_ENABLE,
  input  wire logic                         I_BREAK_FLAG,
  input  wire logic                         I_EDGE_FLAG,
  // To transmitter and receiver
  output logic                              O_SAMPLE_TICK,
  output logic                              O_BIT_TICK,
  output logic                              O_TWO_STOP_BITS,
  output logic                              O_GEN_ACTIVE,
  output logic                              O_IRQ
);

  // ************************************************************
  // Address decode
  // ************************************************************
  // Shared by the read path and the write path
  function automatic ubr_pkg::ubr_sel_t ubr_decode(input logic [ubr_pkg::ADDR_W-1:0] addr);
    ubr_pkg::ubr_sel_t sel;
    if (addr == ubr_pkg::ADDR_HIGH)
      sel = ubr_pkg::SEL_HIGH;
    else if (addr == ubr_pkg::ADDR_LOW)
      sel = ubr_pkg::SEL_LOW;
    else if (addr == ubr_pkg::ADDR_STAT)
      sel = ubr_pkg::SEL_STAT;
    else
      sel = ubr_pkg::SEL_NONE;
    return sel;
  endfunction : ubr_decode

  // ************************************************************
  // Declarations
  // ************************************************************
  ubr_pkg::ubr_apb_st_t          apb_st;
  ubr_pkg::ubr_apb_st_t          next_apb_st;
  logic [ubr_pkg::DATA_W-1:0]    prdata;
  logic [ubr_pkg::DATA_W-1:0]    next_prdata;
  logic                          pready;
  logic                          next_pready;
  logic                          pslverr;
  logic                          next_pslverr;
  ubr_pkg::ubr_sel_t             rd_sel;
  ubr_pkg::ubr_sel_t             wr_sel;
  logic                          wr_fire;

  ubr_pkg::ubr_high_t            high_buf;
  ubr_pkg::ubr_high_t            next_high_buf;
  logic [ubr_pkg::DIV_HI_W-1:0]  div_hi_work;
  logic [ubr_pkg::DIV_HI_W-1:0]  next_div_hi_work;
  logic [ubr_pkg::DIV_LO_W-1:0]  div_lo;
  logic [ubr_pkg::DIV_LO_W-1:0]  next_div_lo;

  logic                          armed;
  logic                          next_armed;
  logic                          gen_active;
  logic                          next_gen_active;
  logic                          irq;
  logic                          next_irq;
  logic                          two_stop;
  logic                          next_two_stop;

  logic [ubr_pkg::DIV_W-1:0]     divisor;
  ubr_pkg::ubr_gen_cfg_t         gen_cfg;
  ubr_pkg::ubr_tick_t            gen_tick;
  logic [ubr_pkg::REG_W-1:0]     high_rd;
  logic [ubr_pkg::REG_W-1:0]     stat_rd;

  // ************************************************************
  // Bus slave
  // ************************************************************
  // Decode both phases from the held address
  assign rd_sel = ubr_decode(I_PADDR);
  assign wr_sel = rd_sel;

  // Writes land only at the access edge with ready high
  assign wr_fire = (apb_st == ubr_pkg::APB_ACCESS) && I_PSEL && I_PENABLE && pready
                   && I_PWRITE && I_PSTRB[0] && !pslverr;

  // Answer is prepared in setup so ready can come from a flop
  always_comb
  begin
    next_apb_st  = apb_st;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (apb_st)
      ubr_pkg::APB_IDLE:
      begin
        if (I_PSEL && !I_PENABLE)
        begin
          next_apb_st  = ubr_pkg::APB_ACCESS;
          next_pready  = 1'b1;
          next_pslverr = (rd_sel == ubr_pkg::SEL_NONE);
          next_prdata  = ubr_pkg::DATA_ZERO;
          if (!I_PWRITE)
          begin
            if (rd_sel == ubr_pkg::SEL_HIGH)
              next_prdata = {24'h000000, high_rd};
            else if (rd_sel == ubr_pkg::SEL_LOW)
              next_prdata = {24'h000000, div_lo};
            else if (rd_sel == ubr_pkg::SEL_STAT)
              next_prdata = {24'h000000, stat_rd};
          end
        end
      end
      ubr_pkg::APB_ACCESS:
      begin
        // One wait-free access cycle, then free for the next setup
        next_apb_st = ubr_pkg::APB_IDLE;
        next_prdata = ubr_pkg::DATA_ZERO;
      end
      default:
      begin
        next_apb_st = ubr_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      apb_st  <= ubr_pkg::APB_IDLE;
      prdata  <= ubr_pkg::DATA_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      apb_st  <= next_apb_st;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ************************************************************
  // Readback views
  // ************************************************************
  // high bits 4 to 0 hold divisor 12 to 8
  assign high_rd = high_buf;

  // Live state of the block for polling
  always_comb
  begin
    stat_rd                       = '0;
    stat_rd[ubr_pkg::ST_ACTIVE]   = gen_active;
    stat_rd[ubr_pkg::ST_ARMED]    = armed;
    stat_rd[ubr_pkg::ST_BRK]      = I_BREAK_FLAG;
    stat_rd[ubr_pkg::ST_EDGE]     = I_EDGE_FLAG;
    stat_rd[ubr_pkg::ST_IRQ]      = irq;
  end

  // ************************************************************
  // Divisor and option registers
  // ************************************************************
  // Readback of the high register shows the buffer, not the working half
  always_comb
  begin
    next_high_buf    = high_buf;
    next_div_hi_work = div_hi_work;
    next_div_lo      = div_lo;
    if (wr_fire && (wr_sel == ubr_pkg::SEL_HIGH))
    begin
      next_high_buf = I_PWDATA[ubr_pkg::REG_W-1:0];
      if (!TWO_STOP_SUPPORT)
        next_high_buf.stop_sel = 1'b0;
    end
    if (wr_fire && (wr_sel == ubr_pkg::SEL_LOW))
    begin
      next_div_lo      = I_PWDATA[ubr_pkg::DIV_LO_W-1:0];
      next_div_hi_work = high_buf.div_hi;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      high_buf    <= ubr_pkg::HIGH_RST;
      div_hi_work <= ubr_pkg::HIGH_RST[ubr_pkg::DIV_HI_W-1:0];
      div_lo      <= ubr_pkg::LOW_RST;
    end
    else
    begin
      high_buf    <= next_high_buf;
      div_hi_work <= next_div_hi_work;
      div_lo      <= next_div_lo;
    end
  end

  // ************************************************************
  // Generator gating
  // ************************************************************
  // one 13-bit working divisor
  assign divisor = {div_hi_work, div_lo};

  always_comb
  begin
    next_armed      = armed || I_RX_ENABLE || I_TX_ENABLE;
    next_gen_active = next_armed && (divisor != ubr_pkg::DIV_ZERO);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      armed      <= 1'b0;
      gen_active <= 1'b0;
    end
    else
    begin
      armed      <= next_armed;
      gen_active <= next_gen_active;
    end
  end

  // Registered run keeps the generator off the enable pins' timing path
  assign gen_cfg.run     = gen_active;
  assign gen_cfg.divisor = divisor;

  ubr_baud_gen u_baud_gen
  (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_cfg  (gen_cfg),
    .o_tick (gen_tick)
  );

  // ************************************************************
  // Options and interrupt request
  // ************************************************************
  // Enables act at once, unlike the buffered divisor half
  always_comb
  begin
    next_irq = high_buf.brk_ie && I_BREAK_FLAG;
    next_irq = next_irq || (high_buf.edge_ie && I_EDGE_FLAG);
    next_two_stop = high_buf.stop_sel;
    if (!TWO_STOP_SUPPORT)
      next_two_stop = 1'b0;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      irq      <= 1'b0;
      two_stop <= 1'b0;
    end
    else
    begin
      irq      <= next_irq;
      two_stop <= next_two_stop;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // All straight from flops, here or in the generator
  assign O_PRDATA        = prdata;
  assign O_PREADY        = pready;
  assign O_PSLVERR       = pslverr;
  assign O_SAMPLE_TICK   = gen_tick.sample;
  assign O_BIT_TICK      = gen_tick.bit_tick;
  assign O_TWO_STOP_BITS = two_stop;
  assign O_GEN_ACTIVE    = gen_active;
  assign O_IRQ           = irq;

endmodule : ubr_regs

/* File: dv/ubr_regs_assertions.sv */
`timescale 1ns/10ps
// ************************
// Register block checker
// ************************
module ubr_regs_checker
(
  // Clock and reset
  input wire logic                       I_CORE_CLK,
  input wire logic                       I_RSTN,
  // Bus
  input wire logic                       I_PSEL,
  input wire logic                       I_PENABLE,
  input wire logic [ubr_pkg::DATA_W-1:0] O_PRDATA,
  input wire logic                       O_PREADY,
  input wire logic                       O_PSLVERR,
  // Side signals
  input wire logic                       I_RX_ENABLE,
  input wire logic                       I_TX_ENABLE,
  input wire logic                       I_BREAK_FLAG,
  input wire logic                       I_EDGE_FLAG,
  input wire logic                       O_SAMPLE_TICK,
  input wire logic                       O_BIT_TICK,
  input wire logic                       O_GEN_ACTIVE,
  input wire logic                       O_IRQ
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  logic armed;
  logic next_armed;
  // Sticky once either enable has been seen
  always_comb next_armed = armed | I_RX_ENABLE | I_TX_ENABLE;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
    if (!I_RSTN) armed <= 1'h0;
    else armed <= next_armed;
  AST_READY_AFTER_SETUP: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  AST_READY_ONE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  AST_UPPER_ZERO: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_IDLE_DATA: assert property (!O_PREADY |-> O_PRDATA == ubr_pkg::DATA_ZERO)
    else $error("read data outside access");
  AST_GEN_IDLE: assert property (!armed |-> !O_GEN_ACTIVE)
    else $error("generator ran before enable");
  AST_TICK_NEEDS_GEN: assert property (O_SAMPLE_TICK |-> $past(O_GEN_ACTIVE))
    else $error("tick while generator stopped");
  AST_BIT_ON_SAMPLE: assert property (O_BIT_TICK |-> O_SAMPLE_TICK)
    else $error("bit tick off sample tick");
  AST_BIT_GAP: assert property (O_BIT_TICK |=> !O_BIT_TICK [*8])
    else $error("bit ticks too close");
  AST_IRQ_CAUSE: assert property (!$past(I_BREAK_FLAG) && !$past(I_EDGE_FLAG) |-> !O_IRQ)
    else $error("interrupt without flag");
  cover property (O_BIT_TICK);
  cover property (O_PSLVERR);
  cover property (O_IRQ);
endmodule : ubr_regs_checker

bind ubr_regs ubr_regs_checker i_ubr_regs_checker (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_RX_ENABLE(I_RX_ENABLE), .I_TX_ENABLE(I_TX_ENABLE),
  .I_BREAK_FLAG(I_BREAK_FLAG), .I_EDGE_FLAG(I_EDGE_FLAG), .O_SAMPLE_TICK(O_SAMPLE_TICK),
  .O_BIT_TICK(O_BIT_TICK), .O_GEN_ACTIVE(O_GEN_ACTIVE), .O_IRQ(O_IRQ));

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  // ****************
  // Signals
  // ****************
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        rx, tx, brk, edg, smp, bitt, two, act, irq, two_m;
  logic [31:0] prdata_m, rdat_m;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdat;
  int          bad_count, n_compared;

  ubr_regs i_ubr_regs (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PADDR(paddr), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_ENABLE(rx),
    .I_TX_ENABLE(tx), .I_BREAK_FLAG(brk), .I_EDGE_FLAG(edg), .O_SAMPLE_TICK(smp),
    .O_BIT_TICK(bitt), .O_TWO_STOP_BITS(two), .O_GEN_ACTIVE(act), .O_IRQ(irq));

  // Build without two stop bits, on the same bus
  ubr_regs #(.TWO_STOP_SUPPORT(1'b0)) i_ubr_regs_masked (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PADDR(paddr),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata_m), .O_PREADY(), .O_PSLVERR(), .I_RX_ENABLE(rx), .I_TX_ENABLE(tx),
    .I_BREAK_FLAG(brk), .I_EDGE_FLAG(edg), .O_SAMPLE_TICK(), .O_BIT_TICK(), .O_TWO_STOP_BITS(two_m),
    .O_GEN_ACTIVE(), .O_IRQ());

  // Free running bus clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat    = prdata;
    rdat_m  = prdata_m;
    rerr    = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h00000000);
    check(name, exp, rdat);
  endtask : rd_chk

  // Cycles between two pulses, sampled on the falling edge
  task automatic period(input string name, input logic sel, input int exp);
    int n;
    n = 0;
    @(negedge clk);
    while ((sel ? bitt : smp) !== 1'h1) @(negedge clk);
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((sel ? bitt : smp) !== 1'h1);
    check(name, exp, n);
  endtask : period

  task automatic results;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd_chk("high", ubr_pkg::ADDR_HIGH, 32'h00000000);
    rd_chk("low", ubr_pkg::ADDR_LOW, 32'h00000004);
    repeat (20) @(negedge clk);
    check("active", 1'h0, act);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rate;
    @(posedge clk);
    tx <= 1'h1;
    repeat (3) @(negedge clk);
    check("active", 1'h1, act);
    @(posedge clk);
    tx <= 1'h0;
    period("sample", 1'h0, 4);
    period("bit", 1'h1, 64);
    $display("test rate done");
  endtask : t_rate

  task automatic t_buffer;
    int seen;
    seen = 0;
    apb(1'h1, ubr_pkg::ADDR_LOW, 32'h00000000);
    rx <= 1'h1;
    repeat (3) @(negedge clk);
    check("active", 1'h0, act);
    repeat (20)
    begin
      @(negedge clk);
      if (smp === 1'h1) seen++;
    end
    check("ticks", 0, seen);
    apb(1'h1, ubr_pkg::ADDR_HIGH, 32'h00000001);
    repeat (3) @(negedge clk);
    check("active", 1'h0, act);
    apb(1'h1, ubr_pkg::ADDR_LOW, 32'h00000002);
    repeat (3) @(negedge clk);
    check("active", 1'h1, act);
    period("sample", 1'h0, 258);
    rd_chk("status", ubr_pkg::ADDR_STAT, 32'h00000003);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_opts;
    apb(1'h1, ubr_pkg::ADDR_HIGH, 32'h000000e0);
    rd_chk("high", ubr_pkg::ADDR_HIGH, 32'h000000e0);
    check("two stop", 1'h1, two);
    check("high masked", 32'h000000c0, rdat_m);
    check("two stop masked", 1'h0, two_m);
    @(posedge clk);
    brk <= 1'h1;
    repeat (3) @(negedge clk);
    check("irq break", 1'h1, irq);
    @(posedge clk);
    brk <= 1'h0;
    edg <= 1'h1;
    repeat (3) @(negedge clk);
    check("irq edge", 1'h1, irq);
    apb(1'h1, ubr_pkg::ADDR_HIGH, 32'h00000000);
    brk <= 1'h1;
    repeat (3) @(negedge clk);
    check("irq masked", 1'h0, irq);
    check("two stop", 1'h0, two);
    @(posedge clk);
    brk <= 1'h0;
    edg <= 1'h0;
    $display("test options done");
  endtask : t_opts

  task automatic t_err;
    apb(1'h0, 12'h00c, 32'h00000000);
    check("error", 1'h1, rerr);
    check("error data", 32'h00000000, rdat);
    @(posedge clk);
    pstrb <= 4'h0;
    apb(1'h1, ubr_pkg::ADDR_HIGH, 32'h000000ff);
    @(posedge clk);
    pstrb <= 4'h1;
    rd_chk("high", ubr_pkg::ADDR_HIGH, 32'h00000000);
    $display("test error done");
  endtask : t_err

  // Main sequence
  initial
  begin
    {rstn, psel, penable, pwrite, rx, tx, brk, edg} = 8'h00;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    pstrb      = 4'h1;
    bad_count  = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    t_reset();
    t_rate();
    t_buffer();
    t_opts();
    t_err();
    results();
  end

  // Hang guard, well beyond the longest run
  initial
  begin
    repeat (10000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : tb_top
